/* design/scre_defines.vh */
// Constants for the serial command and reply engine
`ifndef SCRE_DEFINES_VH
`define SCRE_DEFINES_VH
`define SCRE_A_CTRL 5'h00
`define SCRE_A_STAT 5'h04
`define SCRE_A_MASK 5'h08
`define SCRE_A_INFO 5'h0c
`define SCRE_A_RXD 5'h10
`define SCRE_A_REPLY 5'h14
`define SCRE_A_TXD 5'h18
`define SCRE_C_PROTO 0
`define SCRE_C_TERM_LO 1
`define SCRE_C_TERM_HI 2
`define SCRE_C_ECHO 3
`define SCRE_C_STATEN 4
`define SCRE_C_PUSH 5
`define SCRE_C_BAUD_LO 6
`define SCRE_C_BAUD_HI 8
`define SCRE_CTRL_RST 9'h100
`define SCRE_S_CMD 0
`define SCRE_S_OVR 1
`define SCRE_S_SENT 2
`define SCRE_R_QUERY 4
`define SCRE_R_FETCH 5
`define SCRE_T_LAST 8
`define SCRE_TERM_CR 2'h1
`define SCRE_TERM_CRLF 2'h2
`define SCRE_CHAR_LF 8'h0a
`define SCRE_CHAR_CR 8'h0d
`define SCRE_CHAR_STAR 8'h2a
`define SCRE_CHAR_E 8'h45
`define SCRE_CHAR_ZERO 8'h30
`define SCRE_CHAR_NINE 8'h39
`define SCRE_CHAR_DOT 8'h2e
`define SCRE_CODE_OVERRUN 4'h4
`define SCRE_CODE_TOOLONG 4'h9
`define SCRE_CODE_UNKNOWN 4'hb
`define SCRE_CODE_TEN 4'ha
`define SCRE_CODE_CHARS 2'h3
`define SCRE_BUF_MAX 10'h3e8
`define SCRE_NUM_MAX 5'h14
`define SCRE_DIV_9600 14'h32dd
`define SCRE_DIV_19200 14'h196e
`define SCRE_DIV_38400 14'h0cb7
`define SCRE_DIV_57600 14'h087a
`define SCRE_DIV_115200 14'h043d
`define SCRE_STOP_BIT 4'h9
`define SCRE_FRAME_BITS 4'ha
`define SCRE_TOUT_MIN_CYC 23'h1312d0
`define SCRE_TOUT_STEPS 3'h5
`endif

/* design/scre_uart_rx.v */
// Serial receiver, 8 data bits, 1 stop bit, no parity
`timescale 1ns/1ps
`include "scre_defines.vh"
module scre_uart_rx (
	input wire clk_sys,
	input wire rst,
	input wire [13:0] divisor,
	input wire serialIn,
	output reg byteValid,
	output reg [7:0] byteData
);
reg busy;
reg [13:0] cnt;
reg [3:0] bitIdx;
reg [7:0] shift;
always @(posedge clk_sys) begin
	if (rst) begin
		busy <= 1'b0;
		cnt <= 14'h0;
		bitIdx <= 4'h0;
		shift <= 8'h0;
		byteValid <= 1'b0;
		byteData <= 8'h0;
	end else begin
		byteValid <= 1'b0;
		if (!busy) begin
			if (!serialIn) begin
				busy <= 1'b1;
				cnt <= divisor >> 1;
				bitIdx <= 4'h0;
			end
		end else if (cnt != 14'h0) begin
			cnt <= cnt - 14'h1;
		end else begin
			cnt <= divisor - 14'h1;
			bitIdx <= bitIdx + 4'h1;
			if (bitIdx == 4'h0) begin
				if (serialIn)
					busy <= 1'b0;
			end else if (bitIdx < `SCRE_STOP_BIT) begin
				shift <= {serialIn, shift[7:1]};
			end else begin
				busy <= 1'b0;
				if (serialIn) begin
					byteValid <= 1'b1;
					byteData <= shift;
				end
			end
		end
	end
end
endmodule

/* design/scre_uart_tx.v */
// Serial transmitter, 8 data bits, 1 stop bit, no parity
`timescale 1ns/1ps
`include "scre_defines.vh"
module scre_uart_tx (
	input wire clk_sys,
	input wire rst,
	input wire [13:0] divisor,
	input wire byteValid,
	input wire [7:0] byteData,
	output wire byteReady,
	output reg serialOut
);
reg busy;
reg [13:0] cnt;
reg [3:0] left;
reg [9:0] shift;
assign byteReady = !busy;
always @(posedge clk_sys) begin
	if (rst) begin
		busy <= 1'b0;
		cnt <= 14'h0;
		left <= 4'h0;
		shift <= 10'h3ff;
		serialOut <= 1'b1;
	end else if (!busy) begin
		if (byteValid) begin
			busy <= 1'b1;
			shift <= {1'b1, byteData, 1'b0};
			left <= `SCRE_FRAME_BITS;
			cnt <= 14'h0;
		end
	end else if (cnt != 14'h0) begin
		cnt <= cnt - 14'h1;
	end else if (left == 4'h0) begin
		busy <= 1'b0;
	end else begin
		serialOut <= shift[0];
		shift <= {1'b1, shift[9:1]};
		left <= left - 4'h1;
		cnt <= divisor - 14'h1;
	end
end
endmodule

/* design/scre_engine.v */
// Serial command front end: receive buffer, end detection, replies
// Functional notes
// - Every text-mode message ends with selected terminator
// - Unterminated command completes after baud-scaled idle timeout
// - Text settings ignored under binary protocol
// - Echo returns every received byte unchanged
// - Status replies report outcome of every instruction
// - Query returns result, or error code
// - Valueless instruction replies no-error or error code
// - Distinct codes: unknown, bad parameter, missing
// - Buffer holds 1000 bytes, beyond raises overrun
// - Distinct codes: syntax, separator, multiplier, numeric
// - Numeric value over 20 bytes raises error
// - Command not permitted now gets own code
// - Other failures use one catch-all code
// - Status replies disabled: no error codes sent
// - Push mode sends each measurement automatically
// - Characters framed 8N1 at selected baud
// - Text or binary protocol, exactly one
`timescale 1ns/1ps
`include "scre_defines.vh"
module scre_engine #(
	parameter [22:0] TOUT_MIN_CYC = `SCRE_TOUT_MIN_CYC
) (
	input wire clk_sys,
	input wire rst,
	input wire [4:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdata,
	output wire irq,
	input wire serialRx,
	output wire serialTx,
	input wire measValid,
	input wire [7:0] measData,
	input wire measLast,
	output wire measReady
);
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_CODE = 4'h2;
localparam [3:0] ST_DATA = 4'h4;
localparam [3:0] ST_TERM = 4'h8;

////////////////////////////////////////////////////////////////////////////
// Configuration and interrupt registers
reg [8:0] ctrl;
reg [2:0] status;
reg [2:0] mask;
wire textMode = !ctrl[`SCRE_C_PROTO];
wire [1:0] termSel = ctrl[`SCRE_C_TERM_HI:`SCRE_C_TERM_LO];
wire echoOn = textMode && ctrl[`SCRE_C_ECHO];
wire statOn = textMode && ctrl[`SCRE_C_STATEN];
wire pushOn = textMode && ctrl[`SCRE_C_PUSH];
wire [2:0] baudSel = ctrl[`SCRE_C_BAUD_HI:`SCRE_C_BAUD_LO];
wire wrCtrl = regWr && regAddr == `SCRE_A_CTRL;
wire wrStat = regWr && regAddr == `SCRE_A_STAT;
wire wrMask = regWr && regAddr == `SCRE_A_MASK;
wire wrRxd = regWr && regAddr == `SCRE_A_RXD;
wire wrReply = regWr && regAddr == `SCRE_A_REPLY;
wire wrTxd = regWr && regAddr == `SCRE_A_TXD;
wire rdRxd = regRd && regAddr == `SCRE_A_RXD;

////////////////////////////////////////////////////////////////////////////
// Baud divisor and idle timeout
reg [13:0] divisor;
reg [2:0] toutMult;
always @* begin
	case (baudSel)
	3'h0: begin
		divisor = `SCRE_DIV_9600;
		toutMult = `SCRE_TOUT_STEPS;
	end
	3'h1: begin
		divisor = `SCRE_DIV_19200;
		toutMult = `SCRE_TOUT_STEPS - 3'h1;
	end
	3'h2: begin
		divisor = `SCRE_DIV_38400;
		toutMult = `SCRE_TOUT_STEPS - 3'h2;
	end
	3'h3: begin
		divisor = `SCRE_DIV_57600;
		toutMult = `SCRE_TOUT_STEPS - 3'h3;
	end
	default: begin
		divisor = `SCRE_DIV_115200;
		toutMult = `SCRE_TOUT_STEPS - 3'h4;
	end
	endcase
end
wire [25:0] toutProd = TOUT_MIN_CYC * toutMult;
wire [22:0] toutTarget = toutProd[22:0];

////////////////////////////////////////////////////////////////////////////
// Serial character framing
wire rxValid;
wire [7:0] rxData;
reg txValid;
reg [7:0] txByte;
wire txReady;
scre_uart_rx uRx (
	.clk_sys(clk_sys),
	.rst(rst),
	.divisor(divisor),
	.serialIn(serialRx),
	.byteValid(rxValid),
	.byteData(rxData)
);
scre_uart_tx uTx (
	.clk_sys(clk_sys),
	.rst(rst),
	.divisor(divisor),
	.byteValid(txValid),
	.byteData(txByte),
	.byteReady(txReady),
	.serialOut(serialTx)
);

////////////////////////////////////////////////////////////////////////////
// Receive buffer and command end detection
reg [7:0] rxBuf [0:999];
reg [9:0] rxCount;
reg [9:0] rdPtr;
reg cmdPending;
reg ovrFlag;
reg longFlag;
reg [4:0] numRun;
reg [22:0] idleCnt;
wire isTerm = textMode &&
	(rxData == `SCRE_CHAR_LF || rxData == `SCRE_CHAR_CR);
wire isNum = (rxData >= `SCRE_CHAR_ZERO && rxData <= `SCRE_CHAR_NINE) ||
	rxData == `SCRE_CHAR_DOT;
wire bufFull = rxCount == `SCRE_BUF_MAX;
wire storeByte = rxValid && !isTerm && !bufFull;
wire ovrEvent = rxValid && !isTerm && bufFull;
wire timedOut = idleCnt >= toutTarget;
wire cmdEnd = !cmdPending && rxCount != 10'h0 &&
	((rxValid && isTerm) || (!rxValid && timedOut));
always @(posedge clk_sys) begin
	if (storeByte)
		rxBuf[rxCount] <= rxData;
end
always @(posedge clk_sys) begin
	if (rst) begin
		rxCount <= 10'h0;
		cmdPending <= 1'b0;
		ovrFlag <= 1'b0;
		longFlag <= 1'b0;
		numRun <= 5'h0;
		idleCnt <= 23'h0;
	end else if (wrReply) begin
		rxCount <= 10'h0;
		cmdPending <= 1'b0;
		ovrFlag <= 1'b0;
		longFlag <= 1'b0;
		numRun <= 5'h0;
		idleCnt <= 23'h0;
	end else begin
		if (storeByte)
			rxCount <= rxCount + 10'h1;
		if (ovrEvent)
			ovrFlag <= 1'b1;
		if (cmdEnd)
			cmdPending <= 1'b1;
		if (rxValid)
			idleCnt <= 23'h0;
		else if (rxCount != 10'h0 && !cmdPending && !timedOut)
			idleCnt <= idleCnt + 23'h1;
		if (rxValid && !isTerm) begin
			if (!isNum)
				numRun <= 5'h0;
			else if (numRun == `SCRE_NUM_MAX)
				longFlag <= 1'b1;
			else
				numRun <= numRun + 5'h1;
		end else if (rxValid) begin
			numRun <= 5'h0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// Reply code selection
wire [3:0] swCode = (regWdata[3:0] > `SCRE_CODE_UNKNOWN) ?
	`SCRE_CODE_UNKNOWN : regWdata[3:0];
wire hwFault = ovrFlag || longFlag;
wire [3:0] hwCode = ovrFlag ? `SCRE_CODE_OVERRUN :
	longFlag ? `SCRE_CODE_TOOLONG : swCode;
wire isQuery = regWdata[`SCRE_R_QUERY];
wire codeWanted = statOn &&
	(!isQuery || hwFault || swCode != 4'h0);

////////////////////////////////////////////////////////////////////////////
// Transmit message sequencer
reg [3:0] state;
reg codePend;
reg [3:0] codeVal;
reg [3:0] sendCode;
reg [1:0] charIdx;
reg termIdx;
reg srcMeas;
reg swValid;
reg [7:0] swByte;
reg swLast;
reg fetchArm;
reg echoPend;
reg [7:0] echoByte;
wire measOk = textMode && (pushOn || fetchArm);
wire [3:0] onesVal = (sendCode >= `SCRE_CODE_TEN) ?
	sendCode - `SCRE_CODE_TEN : sendCode;
wire [7:0] tensChar = (sendCode >= `SCRE_CODE_TEN) ?
	`SCRE_CHAR_ZERO + 8'h1 : `SCRE_CHAR_ZERO;
wire [7:0] onesChar = `SCRE_CHAR_ZERO + {4'h0, onesVal};
wire [7:0] termChar = (termSel == `SCRE_TERM_CR ||
	(termSel == `SCRE_TERM_CRLF && !termIdx)) ?
	`SCRE_CHAR_CR : `SCRE_CHAR_LF;
wire dataLast = srcMeas ? measLast : swLast;
wire msgFire = txValid && txReady && !echoPend;
wire echoFire = txValid && txReady && echoPend;
wire msgDone = msgFire && ((state == ST_TERM &&
	(termSel != `SCRE_TERM_CRLF || termIdx)) ||
	(state == ST_DATA && dataLast && !textMode));
assign measReady = (!measOk && state == ST_IDLE) ||
	(state == ST_DATA && srcMeas && !echoPend && txReady);
always @* begin
	txValid = 1'b0;
	txByte = 8'h0;
	if (echoPend) begin
		txValid = 1'b1;
		txByte = echoByte;
	end else begin
		case (state)
		ST_CODE: begin
			txValid = 1'b1;
			case (charIdx)
			2'h0: txByte = `SCRE_CHAR_STAR;
			2'h1: txByte = `SCRE_CHAR_E;
			2'h2: txByte = tensChar;
			default: txByte = onesChar;
			endcase
		end
		ST_DATA: begin
			txValid = srcMeas ? measValid : swValid;
			txByte = srcMeas ? measData : swByte;
		end
		ST_TERM: begin
			txValid = 1'b1;
			txByte = termChar;
		end
		default: begin
			txValid = 1'b0;
			txByte = 8'h0;
		end
		endcase
	end
end
always @(posedge clk_sys) begin
	if (rst) begin
		state <= ST_IDLE;
		codePend <= 1'b0;
		codeVal <= 4'h0;
		sendCode <= 4'h0;
		charIdx <= 2'h0;
		termIdx <= 1'b0;
		srcMeas <= 1'b0;
		swValid <= 1'b0;
		swByte <= 8'h0;
		swLast <= 1'b0;
		fetchArm <= 1'b0;
		echoPend <= 1'b0;
		echoByte <= 8'h0;
	end else begin
		if (echoFire)
			echoPend <= 1'b0;
		if (rxValid && echoOn) begin
			echoPend <= 1'b1;
			echoByte <= rxData;
		end
		case (state)
		ST_IDLE: begin
			if (codePend) begin
				state <= ST_CODE;
				sendCode <= codeVal;
				codePend <= 1'b0;
				charIdx <= 2'h0;
			end else if (swValid) begin
				state <= ST_DATA;
				srcMeas <= 1'b0;
			end else if (measOk && measValid) begin
				state <= ST_DATA;
				srcMeas <= 1'b1;
			end
		end
		ST_CODE: begin
			if (msgFire) begin
				if (charIdx == `SCRE_CODE_CHARS) begin
					state <= ST_TERM;
					termIdx <= 1'b0;
				end else begin
					charIdx <= charIdx + 2'h1;
				end
			end
		end
		ST_DATA: begin
			if (msgFire) begin
				if (!srcMeas)
					swValid <= 1'b0;
				if (srcMeas && measLast)
					fetchArm <= 1'b0;
				if (dataLast) begin
					state <= textMode ? ST_TERM : ST_IDLE;
					termIdx <= 1'b0;
				end
			end
		end
		ST_TERM: begin
			if (msgFire) begin
				if (termSel == `SCRE_TERM_CRLF && !termIdx)
					termIdx <= 1'b1;
				else
					state <= ST_IDLE;
			end
		end
		default: state <= ST_IDLE;
		endcase
		if (wrReply) begin
			if (codeWanted) begin
				codePend <= 1'b1;
				codeVal <= hwCode;
			end
			if (regWdata[`SCRE_R_FETCH] && textMode)
				fetchArm <= 1'b1;
		end
		if (wrTxd) begin
			swValid <= 1'b1;
			swByte <= regWdata[7:0];
			swLast <= regWdata[`SCRE_T_LAST];
		end
		if (codeWanted && wrReply)
			codeVal <= (hwFault || swCode != 4'h0) ?
				hwCode : swCode;
	end
end

////////////////////////////////////////////////////////////////////////////
// Register bus: writes, sticky status, read data
wire [2:0] events = {msgDone, ovrEvent, cmdEnd};
assign irq = |(status & mask);
always @(posedge clk_sys) begin
	if (rst) begin
		ctrl <= `SCRE_CTRL_RST;
		status <= 3'h0;
		mask <= 3'h0;
		rdPtr <= 10'h0;
		regRdata <= 32'h0;
	end else begin
		if (wrCtrl)
			ctrl <= regWdata[8:0];
		if (wrMask)
			mask <= regWdata[2:0];
		status <= (status & ~(wrStat ? regWdata[2:0] : 3'h0)) | events;
		if (wrRxd)
			rdPtr <= regWdata[9:0];
		else if (wrReply)
			rdPtr <= 10'h0;
		else if (rdRxd)
			rdPtr <= rdPtr + 10'h1;
		regRdata <= 32'h0;
		if (regRd) begin
			case (regAddr)
			`SCRE_A_CTRL: regRdata <= {23'h0, ctrl};
			`SCRE_A_STAT: regRdata <= {29'h0, status};
			`SCRE_A_MASK: regRdata <= {29'h0, mask};
			`SCRE_A_INFO: regRdata <= {18'h0, longFlag, ovrFlag,
				!swValid, cmdPending, rxCount};
			`SCRE_A_RXD: regRdata <= (rdPtr < `SCRE_BUF_MAX) ?
				{24'h0, rxBuf[rdPtr]} : 32'h0;
			default: regRdata <= 32'h0;
			endcase
		end
	end
end
endmodule

/* tb/scre_engine_asserts.sv */
// Port assertions for the serial command engine
`timescale 1ns/1ps
module scre_engine_asserts #(
	parameter [22:0] TOUT_MIN_CYC = 23'h1312d0
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [4:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic irq,
	input wire logic serialRx,
	input wire logic serialTx,
	input wire logic measValid,
	input wire logic [7:0] measData,
	input wire logic measLast,
	input wire logic measReady
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////////
sequence s_ctrl_wr_rd;
	regWr && regAddr == 5'h00 ##1 regRd && regAddr == 5'h00;
endsequence
a_ctrl_back: assert property (
	s_ctrl_wr_rd |=> regRdata[8:0] == $past(regWdata[8:0], 2))
	else $error("Control readback differs");
a_rdata_idle: assert property (
	!regRd |=> regRdata == 32'h0) else $error("Read data not zero");
a_unmapped_zero: assert property (
	regRd && regAddr == 5'h1c |=> regRdata == 32'h0)
	else $error("Unmapped read not zero");
a_mask_off: assert property (
	regWr && regAddr == 5'h08 && regWdata[2:0] == 3'h0 |=> !irq)
	else $error("Interrupt with mask cleared");
a_tx_reset: assert property (
	$past(rst) |-> serialTx) else $error("Line not idle after reset");
a_irq_reset: assert property (
	$past(rst) |-> !irq) else $error("Interrupt after reset");
a_ready_reset: assert property (
	$past(rst) |-> measReady) else $error("Measurements not drained");
a_tx_start: assert property (
	$fell(serialTx) |-> !serialTx [*8]) else $error("Start bit too short");
a_tx_bits: assert property (
	$changed(serialTx) |=> $stable(serialTx) [*7])
	else $error("Serial bit too short");
endmodule
bind scre_engine scre_engine_asserts #(.TOUT_MIN_CYC(TOUT_MIN_CYC))
	scre_engine_asserts_inst (.clk_sys(clk_sys), .rst(rst),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .irq(irq), .serialRx(serialRx),
	.serialTx(serialTx), .measValid(measValid), .measData(measData),
	.measLast(measLast), .measReady(measReady));

/* tb/scre_host_model.sv */
// Host side of the serial link: sends bytes, collects replies
`timescale 1ns/1ps
module scre_host_model #(
	parameter int BIT = 1085
) (
	input wire logic clk_sys,
	input wire logic devTx,
	output logic hostTx
);
logic [7:0] q[$];
logic [7:0] b;
int starts = 0;
initial hostTx = 1'b1;
////////////////////////////////////////////////////////////////////////////
// Start bit, eight data bits first bit lowest, one stop bit
task automatic sendByte(input logic [7:0] v);
	logic [9:0] f;
	f = {1'b1, v, 1'b0};
	for (int i = 0; i < 10; i++) begin
		hostTx <= f[i];
		repeat (BIT) @(posedge clk_sys);
	end
endtask
////////////////////////////////////////////////////////////////////////////
// Receiver samples each data bit in its middle
always begin
	@(negedge devTx);
	starts++;
	repeat (BIT / 2) @(posedge clk_sys);
	for (int i = 0; i < 8; i++) begin
		repeat (BIT) @(posedge clk_sys);
		b[i] = devTx;
	end
	repeat (BIT) @(posedge clk_sys);
	q.push_back(b);
end
endmodule

/* tb/tb.sv */
// Testbench for the serial command engine
`timescale 1ns/1ps
`include "scre_defines.vh"
module tb;
logic clk_sys = 1'b0;
logic rst = 1'b1;
logic [4:0] regAddr = 5'h00;
logic [31:0] regWdata = 32'h0;
logic regWr = 1'b0;
logic regRd = 1'b0;
logic [31:0] regRdata;
logic irq;
logic serialRx;
logic serialTx;
logic measValid = 1'b0;
logic [7:0] measData = 8'h00;
logic measLast = 1'b0;
logic measReady;
logic [31:0] d;
logic [7:0] e[9] = '{8'h41, 8'h2a, 8'h45, 8'h30, 8'h30, 8'h0d, 8'h0a,
	8'h4d, 8'h0a};
int n_errors = 0;
int comparisons = 0;
always #4 clk_sys = ~clk_sys;
scre_engine #(.TOUT_MIN_CYC(23'hc8)) scre_engine_inst (
	.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
	.serialRx(serialRx), .serialTx(serialTx), .measValid(measValid),
	.measData(measData), .measLast(measLast), .measReady(measReady));
scre_host_model scre_host_model_inst (.clk_sys(clk_sys), .devTx(serialTx),
	.hostTx(serialRx));
////////////////////////////////////////////////////////////////////////////
task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
	comparisons++;
	if (got !== exp) begin
		n_errors++;
		$display("Error %s expected %h seen %h", name, exp, got);
	end
endtask
task rd(input logic [4:0] a);
	regRd <= 1'b1;
	regAddr <= a;
	@(posedge clk_sys);
	regRd <= 1'b0;
	#1 d = regRdata;
	@(posedge clk_sys);
endtask
task wr(input logic [4:0] a, input logic [31:0] v, input logic back = 0);
	regWr <= 1'b1;
	regAddr <= a;
	regWdata <= v;
	@(posedge clk_sys);
	regWr <= 1'b0;
	if (back) rd(a);
	else @(posedge clk_sys);
endtask
task waitq(input int n, input int lim);
	for (int i = 0; i < lim && scre_host_model_inst.q.size() < n; i++)
		@(posedge clk_sys);
	if (scre_host_model_inst.q.size() < n)
		n_errors++;
endtask
task wrap_up;
	$display("Checks %0d mismatches %0d", comparisons, n_errors);
	if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
	else $display("MISMATCHES SEEN");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
	repeat (115000) @(posedge clk_sys);
	n_errors++;
	wrap_up;
end
initial begin
	repeat (20) @(posedge clk_sys);
	rst <= 1'b0;
	@(posedge clk_sys);
	rd(`SCRE_A_CTRL);
	chk("ctrl reset", d, 32'h100);
	rd(5'h1c);
	chk("unmapped", d, 32'h0);
	chk("meas drained", measReady, 32'h1);
	wr(`SCRE_A_MASK, 32'h1);
	wr(`SCRE_A_CTRL, 32'h11c, 1);
	chk("ctrl", d, 32'h11c);
	scre_host_model_inst.sendByte(8'h41);
	for (int i = 0; i < 2000 && !irq; i++) @(posedge clk_sys);
	chk("cmd end", irq, 32'h1);
	wr(`SCRE_A_RXD, 32'h0);
	rd(`SCRE_A_RXD);
	chk("stored", d[7:0], 32'h41);
	wr(`SCRE_A_STAT, 32'h7);
	chk("irq clear", irq, 32'h0);
	wr(`SCRE_A_REPLY, 32'h0);
	waitq(7, 90000);
	for (int i = 0; i < 7; i++)
		chk("echo reply", scre_host_model_inst.q[i], e[i]);
	wr(`SCRE_A_CTRL, 32'h100);
	wr(`SCRE_A_REPLY, 32'h1);
	measData <= 8'h4d;
	measLast <= 1'b1;
	measValid <= 1'b1;
	repeat (500) @(posedge clk_sys);
	chk("quiet", scre_host_model_inst.starts, 32'd7);
	wr(`SCRE_A_CTRL, 32'h110);
	wr(`SCRE_A_REPLY, 32'h10);
	repeat (500) @(posedge clk_sys);
	chk("query ok", scre_host_model_inst.starts, 32'd7);
	wr(`SCRE_A_CTRL, 32'h111);
	wr(`SCRE_A_REPLY, 32'h2);
	repeat (500) @(posedge clk_sys);
	chk("binary", scre_host_model_inst.starts, 32'd7);
	wr(`SCRE_A_CTRL, 32'h120);
	@(posedge clk_sys);
	for (int i = 0; i < 100 && measReady !== 1'b1; i++)
		@(posedge clk_sys);
	measValid <= 1'b0;
	waitq(9, 30000);
	for (int i = 7; i < 9; i++)
		chk("push", scre_host_model_inst.q[i], e[i]);
	wr(`SCRE_A_MASK, 32'h0);
	wrap_up;
end
endmodule
